// ===== testbench/interrupt_vector_placement_test.sv
// self-checking bench for the interrupt vector placement block
`timescale 1ns/1ps
`default_nettype none
module interrupt_vector_placement_test;
    localparam logic [15:0] BOOT = 16'h0C00; // boot section start for a 2k byte boot size
    logic clk, nrst = 1'b0, fuse = 1'b1, wr = 1'b0, wr_sel = 1'b0, wr_en = 1'b0, go = 1'b0;
    logic acc_v, ready, fv, is_rst, err, err2, hold, sel, chg, done, got_err, e;
    logic [29:0] irq = 30'h2AAA_AAAA, gated, gated2;
    logic [4:0] vec = 5'h00, acc_vec;
    logic [15:0] faddr, got_addr, rst_addr, vstart, a, err2_cnt = 16'h0000;
    int mismatches = 0, check_count = 0, cycles = 0;

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    ivp_top u_dut (
        .clk(clk), .nrst(nrst), .ce(1'b1), .boot_reset_fuse(fuse), .boot_start_addr(BOOT),
        .ctrl_wr(wr), .ctrl_wr_select(wr_sel), .ctrl_wr_change_enable(wr_en), .irq_req(irq),
        .accept_valid(acc_v), .accept_vector(acc_vec), .ready_ff(ready), .fetch_valid_ff(fv),
        .fetch_addr_ff(faddr), .fetch_is_reset_ff(is_rst), .accept_error_ff(err),
        .irq_req_gated_ff(gated), .irq_hold_ff(hold), .vector_base_select_ff(sel),
        .vector_change_enable_ff(chg), .reset_addr_ff(rst_addr), .vector_start_ff(vstart)
    );

    // variant without the power stage, same inputs as the main instance
    ivp_top #(.HAS_POWER_STAGE(1'b0)) u_nops (
        .clk(clk), .nrst(nrst), .ce(1'b1), .boot_reset_fuse(fuse), .boot_start_addr(BOOT),
        .ctrl_wr(wr), .ctrl_wr_select(wr_sel), .ctrl_wr_change_enable(wr_en), .irq_req(irq),
        .accept_valid(acc_v), .accept_vector(acc_vec), .ready_ff(), .fetch_valid_ff(),
        .fetch_addr_ff(), .fetch_is_reset_ff(), .accept_error_ff(err2),
        .irq_req_gated_ff(gated2), .irq_hold_ff(), .vector_base_select_ff(),
        .vector_change_enable_ff(), .reset_addr_ff(), .vector_start_ff()
    );

    ivp_core_model u_core (
        .clk(clk), .nrst(nrst), .go(go), .vec(vec), .ready_ff(ready), .fetch_valid_ff(fv),
        .accept_error_ff(err), .fetch_addr_ff(faddr), .acc_valid_ff(acc_v),
        .acc_vec_ff(acc_vec), .done_ff(done), .got_addr_ff(got_addr), .got_err_ff(got_err)
    );

    // toggling requests, variant error tally, hang guard
    always @(posedge clk) begin
        irq <= ~irq;
        if (err2 === 1'b1) begin
            err2_cnt <= err2_cnt + 16'h0001;
        end
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            report_and_stop();
        end
    end

    task automatic chk_addr(input string nm, input logic [15:0] x, input logic [15:0] g);
        check_count++;
        if (g !== x) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, x, g);
        end
    endtask

    task automatic chk_bit(input string nm, input logic x, input logic g);
        check_count++;
        if (g !== x) begin
            mismatches++;
            $display("[ERR] %s expected %b seen %b", nm, x, g);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // reset with a given fuse level; the reset fetch comes seven edges after release
    task automatic t_reset(input logic f);
        nrst <= 1'b0;
        fuse <= f;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        repeat (7) @(posedge clk);
        #1;
        chk_bit("reset fetch", 1'b1, fv && is_rst);
        chk_addr("reset addr", f ? 16'h0000 : BOOT, faddr);
        chk_addr("vector start", 16'h0001, vstart);
        chk_bit("select after reset", 1'b0, sel);
        $display("test reset with fuse %b done", f);
    endtask

    // one accept through the core model, bounded wait for its answer
    task automatic t_fetch(input logic [4:0] v);
        int n = 0;
        @(posedge clk);
        go <= 1'b1;
        vec <= v;
        @(posedge clk);
        go <= 1'b0;
        #1;
        while (done !== 1'b1 && n < 10) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk_bit("fetch answered", 1'b1, done);
        a = got_addr;
        e = got_err;
    endtask

    // one control write strobe
    task automatic t_wr(input logic en, input logic s);
        @(posedge clk);
        wr <= 1'b1;
        wr_en <= en;
        wr_sel <= s;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask

    // every vector number in the application table, unused ones included
    task automatic t_table();
        for (int v = 0; v < 32; v++) begin
            t_fetch(v[4:0]);
            if (v < 2) begin
                chk_bit("non interrupt vector error", 1'b1, e);
            end else begin
                chk_bit("vector error", 1'b0, e);
                chk_addr("vector addr", {10'h000, v[4:0], 1'b0} - 16'h0002, a);
            end
        end
        chk_addr("absent power stage errors", 16'h0004, err2_cnt);
        chk_bit("absent power stage requests", 1'b1, gated2 === (~irq & 30'h3FFF_FFCF));
        $display("test vector table done");
    endtask

    // timed change of the base select: move, refusal and expiry
    task automatic t_window();
        t_wr(1'b1, 1'b0);
        chk_bit("hold on enable", 1'b1, hold);
        chk_bit("requests held", 1'b1, gated === 30'h0000_0000);
        t_wr(1'b0, 1'b1);
        chk_bit("select moved", 1'b1, sel);
        chk_bit("enable cleared", 1'b0, chg);
        repeat (3) @(posedge clk);
        #1;
        chk_addr("boot vector start", BOOT + 16'h0002, vstart);
        t_fetch(5'h08);
        chk_addr("boot vector addr", BOOT + 16'h000E, a);
        t_wr(1'b0, 1'b0);
        chk_bit("select locked", 1'b1, sel);
        t_wr(1'b1, 1'b0);
        repeat (3) @(posedge clk);
        t_wr(1'b0, 1'b0);
        chk_bit("window expired", 1'b0, chg);
        chk_bit("select after expiry", 1'b1, sel);
        $display("test change window done");
    endtask

    // programmed fuse keeps the vectors at the application table
    task automatic t_boot_reset();
        t_fetch(5'h1F);
        chk_addr("last vector addr", 16'h003C, a);
        $display("test boot reset done");
    endtask

    initial begin
        t_reset(1'b1);
        t_table();
        t_window();
        t_reset(1'b0);
        t_boot_reset();
        report_and_stop();
    end
endmodule // interrupt_vector_placement_test
`default_nettype wire

// ===== testbench/ivp_checker_assertions.sv
// assertion checker for the vector placement block, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module ivp_checker #(
    parameter bit HAS_POWER_STAGE = 1'b1,
    parameter int NUM_SRC = 30
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic boot_reset_fuse,
    input wire logic [15:0] boot_start_addr,
    input wire logic ctrl_wr,
    input wire logic ctrl_wr_select,
    input wire logic ctrl_wr_change_enable,
    input wire logic [NUM_SRC-1:0] irq_req,
    input wire logic accept_valid,
    input wire logic [4:0] accept_vector,
    input wire logic ready_ff,
    input wire logic fetch_valid_ff,
    input wire logic [15:0] fetch_addr_ff,
    input wire logic fetch_is_reset_ff,
    input wire logic accept_error_ff,
    input wire logic [NUM_SRC-1:0] irq_req_gated_ff,
    input wire logic irq_hold_ff,
    input wire logic vector_base_select_ff,
    input wire logic vector_change_enable_ff,
    input wire logic [15:0] reset_addr_ff,
    input wire logic [15:0] vector_start_ff
);
    logic take, bad, good, ps_vec, en_wr, sel_wr;
    logic [15:0] tbl_addr;

    // decode: 0 and 1 are never interrupts, 6 and 7 exist only with the power stage
    assign take = ce && accept_valid && ready_ff;
    assign ps_vec = accept_vector == 5'h06 || accept_vector == 5'h07;
    assign bad = take && (accept_vector < 5'h02 || (ps_vec && !HAS_POWER_STAGE));
    assign good = take && !bad;
    assign tbl_addr = {10'h000, accept_vector, 1'b0} - 16'h0002;
    assign en_wr = ce && ctrl_wr && ctrl_wr_change_enable;
    assign sel_wr = ce && ctrl_wr && !ctrl_wr_change_enable;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    a_fetch_pulse: assert property (good |-> ##2 fetch_valid_ff && !accept_error_ff)
        else $error("no fetch pulse two cycles after accept");
    a_fetch_addr: assert property (good |-> ##2 fetch_addr_ff == $past(tbl_addr, 2)
        + ($past(vector_base_select_ff) ? boot_start_addr : 16'h0000))
        else $error("fetch address differs from placed table entry");
    a_bad_vector: assert property (bad |-> ##2 accept_error_ff && !fetch_valid_ff)
        else $error("unused vector not flagged");
    a_reset_fetch: assert property ($rose(ready_ff) |-> fetch_valid_ff && fetch_is_reset_ff
        && fetch_addr_ff == reset_addr_ff)
        else $error("reset fetch not launched with ready");
    a_reset_place: assert property (ready_ff |-> reset_addr_ff ==
        (boot_reset_fuse ? 16'h0000 : boot_start_addr))
        else $error("reset address does not follow fuse");
    a_vec_start: assert property ((ready_ff && $stable(vector_base_select_ff)) [*3] |->
        vector_start_ff == (vector_base_select_ff ? boot_start_addr + 16'h0002 : 16'h0001))
        else $error("vector start does not follow base select");
    a_window_close: assert property (en_wr ##1 (!ctrl_wr) [*4] |=>
        $past(vector_change_enable_ff) && !vector_change_enable_ff)
        else $error("change window not closed after four cycles");
    a_select_write: assert property (sel_wr && vector_change_enable_ff |=>
        vector_base_select_ff == $past(ctrl_wr_select) && !vector_change_enable_ff)
        else $error("select write in window not taken");
    a_select_lock: assert property (sel_wr && !vector_change_enable_ff |=>
        $stable(vector_base_select_ff))
        else $error("select changed without open window");
    a_hold_start: assert property (en_wr |=> vector_change_enable_ff && irq_hold_ff
        && irq_req_gated_ff == '0)
        else $error("requests not held off when window opens");
endmodule // ivp_checker

bind ivp_top ivp_checker #(.HAS_POWER_STAGE(HAS_POWER_STAGE), .NUM_SRC(NUM_SRC)) u_chk (
    .clk(clk), .nrst(nrst), .ce(ce), .boot_reset_fuse(boot_reset_fuse),
    .boot_start_addr(boot_start_addr), .ctrl_wr(ctrl_wr), .ctrl_wr_select(ctrl_wr_select),
    .ctrl_wr_change_enable(ctrl_wr_change_enable), .irq_req(irq_req),
    .accept_valid(accept_valid), .accept_vector(accept_vector), .ready_ff(ready_ff),
    .fetch_valid_ff(fetch_valid_ff), .fetch_addr_ff(fetch_addr_ff),
    .fetch_is_reset_ff(fetch_is_reset_ff), .accept_error_ff(accept_error_ff),
    .irq_req_gated_ff(irq_req_gated_ff), .irq_hold_ff(irq_hold_ff),
    .vector_base_select_ff(vector_base_select_ff),
    .vector_change_enable_ff(vector_change_enable_ff), .reset_addr_ff(reset_addr_ff),
    .vector_start_ff(vector_start_ff)
);
`default_nettype wire

// ===== testbench/ivp_core_model.sv
// processor core stand-in: takes one interrupt and captures the fetch answer
`timescale 1ns/1ps
`default_nettype none
module ivp_core_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic go,
    input wire logic [4:0] vec,
    input wire logic ready_ff,
    input wire logic fetch_valid_ff,
    input wire logic accept_error_ff,
    input wire logic [15:0] fetch_addr_ff,
    output logic acc_valid_ff,
    output logic [4:0] acc_vec_ff,
    output logic done_ff,
    output logic [15:0] got_addr_ff,
    output logic got_err_ff
);
    logic busy_ff;
    logic answer;

    assign answer = fetch_valid_ff || accept_error_ff;

    // accept only on request, one pulse, after the reset fetch
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            acc_valid_ff <= 1'b0;
            acc_vec_ff <= 5'h15;
            busy_ff <= 1'b0;
        end else if (go && ready_ff && !busy_ff) begin
            acc_valid_ff <= 1'b1;
            acc_vec_ff <= vec;
            busy_ff <= 1'b1;
        end else begin
            acc_valid_ff <= 1'b0;
            acc_vec_ff <= ~acc_vec_ff; // idle lines churn so stale numbers never look valid
            if (answer) begin
                busy_ff <= 1'b0;
            end
        end
    end

    // capture the answer pulse, it stands for a single cycle only
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            done_ff <= 1'b0;
            got_addr_ff <= 16'h0000;
            got_err_ff <= 1'b0;
        end else begin
            done_ff <= busy_ff && answer;
            if (answer) begin
                got_addr_ff <= fetch_addr_ff;
                got_err_ff <= accept_error_ff;
            end
        end
    end
endmodule // ivp_core_model
`default_nettype wire

// ===== verilog/ivp_params.svh
// constants for the interrupt vector placement block: table addresses, codes, timing
`ifndef IVP_PARAMS_SVH
`define IVP_PARAMS_SVH

// program word addresses of the first vector of each source group
`define IVP_VEC_RESET 16'h0000
`define IVP_VEC_COMP0 16'h0002
`define IVP_VEC_PS_FAULT 16'h000A
`define IVP_VEC_PS_CYCLE_END 16'h000C
`define IVP_VEC_EXT0 16'h000E
`define IVP_VEC_WTIM_CAPTURE 16'h0016
`define IVP_VEC_NTIM_MATCH_A 16'h001E
`define IVP_VEC_CAN_MSG 16'h0024
`define IVP_VEC_CAN_TIMER_OVERFLOW_REQUEST 16'h0026
`define IVP_VEC_LIN_DONE 16'h0028
`define IVP_VEC_LIN_ERR 16'h002A
`define IVP_VEC_PCHG0 16'h002C
`define IVP_VEC_SPI_DONE 16'h0034
`define IVP_VEC_ADC_DONE 16'h0036
`define IVP_VEC_WDOG 16'h0038
`define IVP_VEC_DMEM_READY 16'h003A
`define IVP_VEC_PSTORE_READY 16'h003C

// spacing between two neighbouring vectors, in program words
`define IVP_VEC_STRIDE 16'h0002

// vector numbers of the first vector in each group
`define IVP_NUM_RESET 5'h01
`define IVP_NUM_COMP0 5'h02
`define IVP_NUM_PS_FAULT 5'h06
`define IVP_NUM_PS_CYCLE_END 5'h07
`define IVP_NUM_EXT0 5'h08
`define IVP_NUM_WTIM 5'h0C
`define IVP_NUM_NTIM 5'h10
`define IVP_NUM_CAN_MSG 5'h13
`define IVP_NUM_CAN_TIMER_OVERFLOW_REQUEST 5'h14
`define IVP_NUM_LIN_DONE 5'h15
`define IVP_NUM_LIN_ERR 5'h16
`define IVP_NUM_PCHG0 5'h17
`define IVP_NUM_SPI_DONE 5'h1B
`define IVP_NUM_ADC_DONE 5'h1C
`define IVP_NUM_WDOG 5'h1D
`define IVP_NUM_DMEM_READY 5'h1E
`define IVP_NUM_LAST 5'h1F

// vector table start addresses
`define IVP_APP_VEC_START 16'h0001
`define IVP_BOOT_VEC_OFFSET 16'h0002

// boot-reset fuse coding: 0 programmed, 1 unprogrammed
`define IVP_FUSE_PROGRAMMED 1'b0
`define IVP_FUSE_UNPROGRAMMED 1'b1

// timing counts in core clock cycles
`define IVP_CHG_WINDOW_CYC 3'h4
`define IVP_SETTLE_CYC 3'h5

`endif

// ===== verilog/ivp_pin_sync.sv
// three-stage synchroniser with agreement filter for slow external levels
`timescale 1ns/1ps
`default_nettype none
module ivp_pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level_ff
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            logic s1_ff;
            logic s2_ff;
            logic s3_ff;
            // first stage feeds only the second; the filter sees stages two and three
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    s1_ff <= RST_VAL[i];
                    s2_ff <= RST_VAL[i];
                    s3_ff <= RST_VAL[i];
                    level_ff[i] <= RST_VAL[i];
                end else if (ce) begin
                    s1_ff <= pin_in[i];
                    s2_ff <= s1_ff;
                    s3_ff <= s2_ff;
                    if (s2_ff == s3_ff) begin
                        level_ff[i] <= s3_ff;
                    end
                end
            end
        end
    endgenerate
endmodule // ivp_pin_sync
`default_nettype wire

// ===== verilog/ivp_pkg.sv
// types shared by the interrupt vector placement block
package ivp_pkg;
    typedef logic [15:0] ivp_addr_t;
    typedef logic [4:0] ivp_vecnum_t;
    typedef enum logic [1:0] {
        st_settle,
        st_launch,
        st_run
    } ivp_state_t;
endpackage

// ===== verilog/ivp_top.sv
// interrupt vector placement: reset address, vector base selection and vector fetch
`timescale 1ns/1ps
`default_nettype none
`include "ivp_params.svh"

module ivp_top
    import ivp_pkg::*;
#(
    parameter bit HAS_POWER_STAGE = 1'b1,
    parameter int NUM_SRC = 30
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic boot_reset_fuse,
    input wire logic [15:0] boot_start_addr,
    input wire logic ctrl_wr,
    input wire logic ctrl_wr_select,
    input wire logic ctrl_wr_change_enable,
    input wire logic [NUM_SRC-1:0] irq_req,
    input wire logic accept_valid,
    input wire logic [4:0] accept_vector,
    output logic ready_ff,
    output logic fetch_valid_ff,
    output logic [15:0] fetch_addr_ff,
    output logic fetch_is_reset_ff,
    output logic accept_error_ff,
    output logic [NUM_SRC-1:0] irq_req_gated_ff,
    output logic irq_hold_ff,
    output logic vector_base_select_ff,
    output logic vector_change_enable_ff,
    output logic [15:0] reset_addr_ff,
    output logic [15:0] vector_start_ff
);

    // synchronised external levels
    logic fuse_sync;
    ivp_addr_t boot_sync;

    // straps caught once after reset release
    logic fuse_latched_ff;
    ivp_addr_t boot_latched_ff;

    // reset launch sequencer
    ivp_state_t state_ff;
    ivp_state_t nxt_state;
    logic [2:0] settle_cnt_ff;

    // change window bookkeeping
    logic [2:0] chg_cnt_ff;
    logic hold_tail_ff;

    // vector table read port
    logic rom_rd_en;
    ivp_addr_t rom_addr;
    logic rom_valid;
    logic rom_unused;

    // placement helpers
    ivp_addr_t vec_base;
    ivp_addr_t placed_reset;
    logic [NUM_SRC-1:0] src_mask;
    logic irq_hold_now;

    // the fuse is a slow pin level; it resets to the unprogrammed value
    ivp_pin_sync #(
        .WIDTH(1),
        .RST_VAL(`IVP_FUSE_UNPROGRAMMED)
    ) u_fuse_sync (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .pin_in(boot_reset_fuse),
        .level_ff(fuse_sync)
    );

    // the boot section start comes from fuses as well, so it is filtered the same way
    ivp_pin_sync #(
        .WIDTH(16),
        .RST_VAL(16'h0000)
    ) u_boot_sync (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .pin_in(boot_start_addr),
        .level_ff(boot_sync)
    );

    // table lookup of accepted sources, one cycle latency
    ivp_vec_rom #(
        .HAS_POWER_STAGE(HAS_POWER_STAGE)
    ) u_rom (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .rd_en(rom_rd_en),
        .rd_vec(accept_vector),
        .rd_addr_ff(rom_addr),
        .rd_valid_ff(rom_valid),
        .rd_unused_ff(rom_unused)
    );

    // next state of the launch sequencer
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            st_settle: begin
                if (settle_cnt_ff == `IVP_SETTLE_CYC) begin
                    nxt_state = st_launch;
                end
            end
            st_launch: begin
                nxt_state = st_run;
            end
            st_run: begin
                nxt_state = st_run;
            end
            default: begin
                nxt_state = st_settle;
            end
        endcase
    end

    // state register and settle counter; waits until the filtered straps are valid
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= st_settle;
            settle_cnt_ff <= 3'h0;
        end else if (ce) begin
            state_ff <= nxt_state;
            if (state_ff == st_settle) begin
                settle_cnt_ff <= settle_cnt_ff + 3'h1;
            end
        end
    end

    // straps are caught by the clock after release, never by the reset itself
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fuse_latched_ff <= `IVP_FUSE_UNPROGRAMMED;
            boot_latched_ff <= 16'h0000;
        end else if (ce) begin
            if (state_ff == st_settle && nxt_state == st_launch) begin
                fuse_latched_ff <= fuse_sync;
                boot_latched_ff <= boot_sync;
            end
        end
    end

    // zero on the fuse means programmed
    // programmed fuse moves the reset entry to the boot section
    assign placed_reset = (fuse_latched_ff == `IVP_FUSE_PROGRAMMED) ? boot_latched_ff
                                                                    : `IVP_VEC_RESET;

    // base for every interrupt vector follows the select bit
    assign vec_base = vector_base_select_ff ? boot_latched_ff : 16'h0000;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reset_addr_ff <= `IVP_VEC_RESET;
            vector_start_ff <= `IVP_APP_VEC_START;
        end else if (ce) begin
            reset_addr_ff <= placed_reset;
            if (vector_base_select_ff) begin
                vector_start_ff <= boot_latched_ff + `IVP_BOOT_VEC_OFFSET;
            end else begin
                vector_start_ff <= `IVP_APP_VEC_START;
            end
        end
    end

    // change enable set, window countdown and guarded select write
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            vector_base_select_ff <= 1'b0;
            vector_change_enable_ff <= 1'b0;
            chg_cnt_ff <= 3'h0;
        end else if (ce) begin
            if (ctrl_wr && ctrl_wr_change_enable) begin
                // a new enable write restarts the window; select is left alone
                vector_change_enable_ff <= 1'b1;
                chg_cnt_ff <= `IVP_CHG_WINDOW_CYC;
            end else if (ctrl_wr && vector_change_enable_ff) begin
                // write inside the window takes effect and closes it
                vector_base_select_ff <= ctrl_wr_select;
                vector_change_enable_ff <= 1'b0;
                chg_cnt_ff <= 3'h0;
            end else if (vector_change_enable_ff) begin
                // window closes by itself four cycles after it opened
                chg_cnt_ff <= chg_cnt_ff - 3'h1;
                if (chg_cnt_ff == 3'h1) begin
                    vector_change_enable_ff <= 1'b0;
                end
            end
        end
    end

    // one extra cycle of hold after the select write covers the following instruction
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hold_tail_ff <= 1'b0;
        end else if (ce) begin
            hold_tail_ff <= ctrl_wr && !ctrl_wr_change_enable && vector_change_enable_ff;
        end
    end

    // requests are held off from the cycle the enable is set
    assign irq_hold_now = vector_change_enable_ff || hold_tail_ff
                          || (ctrl_wr && ctrl_wr_change_enable);

    // power stage entries are masked out when that unit is absent
    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g = g + 1) begin : g_mask
            if ((g + 2 == 6 || g + 2 == 7) && !HAS_POWER_STAGE) begin : g_off
                assign src_mask[g] = 1'b0;
            end else begin : g_on
                assign src_mask[g] = 1'b1;
            end
        end
    endgenerate

    // gated request vector toward the core's arbiter
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_req_gated_ff <= '0;
            irq_hold_ff <= 1'b0;
        end else if (ce) begin
            irq_hold_ff <= irq_hold_now;
            if (irq_hold_now || state_ff != st_run) begin
                irq_req_gated_ff <= '0;
            end else begin
                irq_req_gated_ff <= irq_req & src_mask;
            end
        end
    end

    // accepts are only looked up once the reset fetch has gone out
    assign rom_rd_en = accept_valid && (state_ff == st_run);

    // fetch address output: reset launch or placed interrupt vector
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fetch_valid_ff <= 1'b0;
            fetch_addr_ff <= `IVP_VEC_RESET;
            fetch_is_reset_ff <= 1'b0;
            accept_error_ff <= 1'b0;
        end else if (ce) begin
            fetch_valid_ff <= 1'b0;
            fetch_is_reset_ff <= 1'b0;
            accept_error_ff <= 1'b0;
            if (state_ff == st_launch) begin
                fetch_valid_ff <= 1'b1;
                fetch_is_reset_ff <= 1'b1;
                fetch_addr_ff <= placed_reset;
            end else if (rom_valid && rom_unused) begin
                // unused entries never fetch; the core sees an error pulse instead
                accept_error_ff <= 1'b1;
            end else if (rom_valid) begin
                fetch_valid_ff <= 1'b1;
                fetch_addr_ff <= rom_addr + vec_base;
            end
        end
    end

    // ready rises together with the reset fetch pulse
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ready_ff <= 1'b0;
        end else if (ce) begin
            if (state_ff == st_launch) begin
                ready_ff <= 1'b1;
            end
        end
    end

endmodule // ivp_top
`default_nettype wire

// ===== verilog/ivp_vec_rom.sv
// vector table: vector number in, table word address out one cycle later
`timescale 1ns/1ps
`default_nettype none
`include "ivp_params.svh"
module ivp_vec_rom
    import ivp_pkg::*;
#(
    parameter bit HAS_POWER_STAGE = 1'b1
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic rd_en,
    input wire ivp_vecnum_t rd_vec,
    output ivp_addr_t rd_addr_ff,
    output logic rd_valid_ff,
    output logic rd_unused_ff
);
    ivp_addr_t nxt_addr;
    logic nxt_unused;
    ivp_addr_t idx;

    // group base plus stride times position within the group
    always_comb begin
        idx = {11'h000, rd_vec};
        nxt_unused = 1'b0;
        nxt_addr = `IVP_VEC_RESET;
        if (rd_vec >= `IVP_NUM_DMEM_READY) begin
            nxt_addr = `IVP_VEC_DMEM_READY + `IVP_VEC_STRIDE * (idx - 16'(`IVP_NUM_DMEM_READY));
        end else if (rd_vec == `IVP_NUM_WDOG) begin
            nxt_addr = `IVP_VEC_WDOG;
        end else if (rd_vec == `IVP_NUM_ADC_DONE) begin
            nxt_addr = `IVP_VEC_ADC_DONE;
        end else if (rd_vec == `IVP_NUM_SPI_DONE) begin
            nxt_addr = `IVP_VEC_SPI_DONE;
        end else if (rd_vec >= `IVP_NUM_PCHG0) begin
            nxt_addr = `IVP_VEC_PCHG0 + `IVP_VEC_STRIDE * (idx - 16'(`IVP_NUM_PCHG0));
        end else if (rd_vec == `IVP_NUM_LIN_ERR) begin
            nxt_addr = `IVP_VEC_LIN_ERR;
        end else if (rd_vec == `IVP_NUM_LIN_DONE) begin
            nxt_addr = `IVP_VEC_LIN_DONE;
        end else if (rd_vec == `IVP_NUM_CAN_TIMER_OVERFLOW_REQUEST) begin
            nxt_addr = `IVP_VEC_CAN_TIMER_OVERFLOW_REQUEST;
        end else if (rd_vec == `IVP_NUM_CAN_MSG) begin
            nxt_addr = `IVP_VEC_CAN_MSG;
        end else if (rd_vec >= `IVP_NUM_NTIM) begin
            nxt_addr = `IVP_VEC_NTIM_MATCH_A + `IVP_VEC_STRIDE * (idx - 16'(`IVP_NUM_NTIM));
        end else if (rd_vec >= `IVP_NUM_WTIM) begin
            nxt_addr = `IVP_VEC_WTIM_CAPTURE + `IVP_VEC_STRIDE * (idx - 16'(`IVP_NUM_WTIM));
        end else if (rd_vec >= `IVP_NUM_EXT0) begin
            nxt_addr = `IVP_VEC_EXT0 + `IVP_VEC_STRIDE * (idx - 16'(`IVP_NUM_EXT0));
        end else if (rd_vec == `IVP_NUM_PS_CYCLE_END) begin
            nxt_addr = `IVP_VEC_PS_CYCLE_END;
            nxt_unused = !HAS_POWER_STAGE;
        end else if (rd_vec == `IVP_NUM_PS_FAULT) begin
            nxt_addr = `IVP_VEC_PS_FAULT;
            nxt_unused = !HAS_POWER_STAGE;
        end else if (rd_vec >= `IVP_NUM_COMP0) begin
            nxt_addr = `IVP_VEC_COMP0 + `IVP_VEC_STRIDE * (idx - 16'(`IVP_NUM_COMP0));
        end else begin
            // reset and the unused number zero are not interrupt vectors
            nxt_addr = `IVP_VEC_RESET;
            nxt_unused = 1'b1;
        end
    end

    // registered read port
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rd_addr_ff <= 16'h0000;
            rd_valid_ff <= 1'b0;
            rd_unused_ff <= 1'b0;
        end else if (ce) begin
            rd_valid_ff <= rd_en;
            if (rd_en) begin
                rd_addr_ff <= nxt_addr;
                rd_unused_ff <= nxt_unused;
            end
        end
    end
endmodule // ivp_vec_rom
`default_nettype wire
